// [rtl/osu_consts.vh]
// Constants for the flexible second operand shifter and constant expander
`ifndef OSU_CONSTS_VH
`define OSU_CONSTS_VH

// ==========================================================
// Datapath widths
`define OSU_DATA_W 32
`define OSU_IMM_CODE_W 12
`define OSU_IMM_FIELD_W 5
`define OSU_AMT_W 8
`define OSU_KIND_W 3

// ==========================================================
// Shift kinds on shift_kind
`define OSU_KIND_LSL 3'h0
`define OSU_KIND_LSR 3'h1
`define OSU_KIND_ASR 3'h2
`define OSU_KIND_ROR 3'h3
`define OSU_KIND_RRX 3'h4

// ==========================================================
// Encoded constant fields inside imm_code
`define OSU_IMM_BYTE_HI 7
`define OSU_IMM_BYTE_LO 0
`define OSU_IMM_SEL_HI 11
`define OSU_IMM_SEL_LO 10
`define OSU_IMM_PAT_HI 9
`define OSU_IMM_PAT_LO 8
`define OSU_IMM_ROT_HI 11
`define OSU_IMM_ROT_LO 7

// Replication patterns when the select field is zero
`define OSU_PAT_PLAIN 2'h0
`define OSU_PAT_EVEN 2'h1
`define OSU_PAT_ODD 2'h2
`define OSU_PAT_ALL 2'h3

// ==========================================================
// Shift length limits and reset value
`define OSU_FULL_SHIFT 8'h20
`define OSU_ENC_ZERO 5'h00
`define OSU_CARRY_RESET 1'b0

`endif

// [rtl/osu_const_expand.v]
// Expands a 12-bit encoded constant into the 32-bit second operand
`timescale 1ns/1ps
`default_nettype none
`include "osu_consts.vh"

module osu_const_expand (
  input wire [`OSU_IMM_CODE_W-1:0] imm_code,
  output reg [`OSU_DATA_W-1:0] value,
  output reg shifted_form,
  output wire high_bit
);

  wire [7:0] byte_val;
  wire [1:0] sel;
  wire [1:0] pat;
  wire [4:0] rot;
  wire [7:0] seeded;
  wire [63:0] doubled;
  wire [63:0] rotated;

  assign byte_val = imm_code[`OSU_IMM_BYTE_HI:`OSU_IMM_BYTE_LO];
  assign sel = imm_code[`OSU_IMM_SEL_HI:`OSU_IMM_SEL_LO];
  assign pat = imm_code[`OSU_IMM_PAT_HI:`OSU_IMM_PAT_LO];
  assign rot = imm_code[`OSU_IMM_ROT_HI:`OSU_IMM_ROT_LO];
  // Shifted forms always carry a leading one, so the rotate covers
  // every left-shift position of a nonzero byte above 255
  assign seeded = {1'b1, byte_val[6:0]};
  assign doubled = {24'h000000, seeded, 24'h000000, seeded};
  assign rotated = doubled >> rot;

  // ==========================================================
  // Pattern select
  always @*
  begin
    value = {24'h000000, byte_val};
    shifted_form = 1'b0;
    if (sel == 2'h0)
    begin
      case (pat)
        `OSU_PAT_PLAIN: value = {24'h000000, byte_val};
        `OSU_PAT_EVEN: value = {8'h00, byte_val, 8'h00, byte_val};
        `OSU_PAT_ODD: value = {byte_val, 8'h00, byte_val, 8'h00};
        `OSU_PAT_ALL: value = {byte_val, byte_val, byte_val, byte_val};
        default: value = {24'h000000, byte_val};
      endcase
    end
    else
    begin
      value = rotated[31:0];
      shifted_form = 1'b1;
    end
  end

  assign high_bit = value[31];

endmodule
`default_nettype wire

// [rtl/osu_operand_shifter.v]
// Flexible second operand: constant expander, barrel shifter and carry
`timescale 1ns/1ps
`default_nettype none
`include "osu_consts.vh"

module osu_operand_shifter (
  input wire ref_clk,
  input wire reset_n,
  input wire use_immediate,
  input wire [`OSU_IMM_CODE_W-1:0] imm_code,
  input wire [`OSU_DATA_W-1:0] shift_source_register,
  input wire [`OSU_KIND_W-1:0] shift_kind,
  input wire shift_by_register,
  input wire [`OSU_IMM_FIELD_W-1:0] shift_imm_field,
  input wire [`OSU_AMT_W-1:0] shift_reg_amount,
  input wire sets_flags,
  input wire op_execute,
  input wire carry_load,
  input wire carry_load_value,
  output wire [`OSU_DATA_W-1:0] flexible_second_operand,
  output wire shifter_carry_out,
  output wire carry_update,
  output reg carry_flag
);

  // ==========================================================
  // Reset release
  reg rst_meta_n;
  reg rst_n;

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Constant expander
  wire [`OSU_DATA_W-1:0] imm_value;
  wire imm_shifted;
  wire imm_high_bit;

  osu_const_expand u_expand (
    .imm_code(imm_code),
    .value(imm_value),
    .shifted_form(imm_shifted),
    .high_bit(imm_high_bit)
  );

  // ==========================================================
  // Shift decode
  // An immediate field of zero means 32 for right shifts and selects
  // rotate through carry for rotate, so encoded lengths stay in range.
  reg [`OSU_KIND_W-1:0] eff_kind;
  reg [`OSU_AMT_W-1:0] eff_amount;

  always @*
  begin
    eff_kind = shift_kind;
    eff_amount = shift_reg_amount;
    if (!shift_by_register)
    begin
      eff_amount = {3'h0, shift_imm_field};
      case (shift_kind)
        `OSU_KIND_LSL:
        begin
          eff_amount = {3'h0, shift_imm_field};
        end
        `OSU_KIND_LSR, `OSU_KIND_ASR:
        begin
          if (shift_imm_field == `OSU_ENC_ZERO)
            eff_amount = `OSU_FULL_SHIFT;
        end
        `OSU_KIND_ROR:
        begin
          if (shift_imm_field == `OSU_ENC_ZERO)
            eff_kind = `OSU_KIND_RRX;
        end
        `OSU_KIND_RRX:
        begin
          eff_amount = 8'h01;
        end
        default:
        begin
          eff_kind = `OSU_KIND_LSL;
          eff_amount = 8'h00;
        end
      endcase
    end
    else if (shift_kind == `OSU_KIND_RRX)
    begin
      eff_amount = 8'h01;
    end
  end

  // ==========================================================
  // Rotator, one bit slice per result bit
  wire [4:0] rot_by;
  wire [`OSU_DATA_W-1:0] rot_value;

  // Only the low five bits matter: a length above 32 folds onto n mod 32
  assign rot_by = eff_amount[4:0];

  genvar gi;
  generate
    for (gi = 0; gi < `OSU_DATA_W; gi = gi + 1)
    begin : g_rot
      localparam [4:0] BIT_POS = gi;
      wire [4:0] src_pos;
      assign src_pos = BIT_POS + rot_by;
      assign rot_value[gi] = shift_source_register[src_pos];
    end
  endgenerate

  // ==========================================================
  // Shifter proper
  wire [4:0] low_idx;
  wire [4:0] left_idx;
  wire below_full;
  wire at_full;
  wire [`OSU_DATA_W-1:0] lsl_value;
  wire [`OSU_DATA_W-1:0] lsr_value;
  wire [`OSU_DATA_W-1:0] asr_value;

  assign below_full = eff_amount < `OSU_FULL_SHIFT;
  assign at_full = eff_amount == `OSU_FULL_SHIFT;
  // Index of the last bit shifted out on the right, bit n-1
  assign low_idx = eff_amount[4:0] - 5'h01;
  // Index of the last bit shifted out on the left, bit 32-n
  assign left_idx = 5'h00 - eff_amount[4:0];
  assign lsl_value = shift_source_register << eff_amount[4:0];
  assign lsr_value = shift_source_register >> eff_amount[4:0];
  assign asr_value = $signed(shift_source_register) >>> eff_amount[4:0];

  reg [`OSU_DATA_W-1:0] shift_value;
  reg shift_carry;
  reg shift_active;

  always @*
  begin
    shift_value = shift_source_register;
    shift_carry = carry_flag;
    shift_active = eff_amount != 8'h00;
    case (eff_kind)
      `OSU_KIND_LSL:
      begin
        if (!shift_active)
        begin
          shift_value = shift_source_register;
        end
        else if (below_full)
        begin
          shift_value = lsl_value;
          shift_carry = shift_source_register[left_idx];
        end
        else if (at_full)
        begin
          shift_value = 32'h00000000;
          shift_carry = shift_source_register[0];
        end
        else
        begin
          shift_value = 32'h00000000;
          shift_carry = 1'b0;
        end
      end
      `OSU_KIND_LSR:
      begin
        if (!shift_active)
        begin
          shift_value = shift_source_register;
        end
        else if (below_full)
        begin
          shift_value = lsr_value;
          shift_carry = shift_source_register[low_idx];
        end
        else if (at_full)
        begin
          shift_value = 32'h00000000;
          shift_carry = shift_source_register[31];
        end
        else
        begin
          shift_value = 32'h00000000;
          shift_carry = 1'b0;
        end
      end
      `OSU_KIND_ASR:
      begin
        if (!shift_active)
        begin
          shift_value = shift_source_register;
        end
        else if (below_full)
        begin
          shift_value = asr_value;
          shift_carry = shift_source_register[low_idx];
        end
        else
        begin
          shift_value = {32{shift_source_register[31]}};
          shift_carry = shift_source_register[31];
        end
      end
      `OSU_KIND_ROR:
      begin
        if (!shift_active)
        begin
          shift_value = shift_source_register;
        end
        else if (rot_by == 5'h00)
        begin
          // Any nonzero multiple of 32 lands here
          shift_value = shift_source_register;
          shift_carry = shift_source_register[31];
        end
        else
        begin
          shift_value = rot_value;
          shift_carry = shift_source_register[low_idx];
        end
      end
      `OSU_KIND_RRX:
      begin
        shift_active = 1'b1;
        shift_value = {carry_flag, shift_source_register[31:1]};
        shift_carry = shift_source_register[0];
      end
      default:
      begin
        shift_active = 1'b0;
        shift_value = shift_source_register;
      end
    endcase
  end

  // ==========================================================
  // Operand select and carry-out
  // Kept combinational so the execute stage sees the operand and carry
  // in the cycle the decode presents them; only the flag is registered.
  reg carry_source;
  reg carry_moves;

  always @*
  begin
    if (use_immediate)
    begin
      carry_source = imm_high_bit;
      carry_moves = imm_shifted;
    end
    else
    begin
      carry_source = shift_carry;
      carry_moves = shift_active;
    end
  end

  assign flexible_second_operand =
    use_immediate ? imm_value : shift_value;
  assign carry_update = sets_flags & carry_moves;
  assign shifter_carry_out =
    carry_update ? carry_source : carry_flag;

  // ==========================================================
  // Carry flag
  // A flag-setting operation that executes wins over a load from the
  // arithmetic side in the same cycle; the decode never issues both.
  reg next_carry_flag;

  always @*
  begin
    next_carry_flag = carry_flag;
    if (op_execute && carry_update)
      next_carry_flag = carry_source;
    else if (carry_load)
      next_carry_flag = carry_load_value;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      carry_flag <= `OSU_CARRY_RESET;
    else
      carry_flag <= next_carry_flag;
  end

endmodule
`default_nettype wire

// [tb/osu_regfile_model.sv]
// Register file stand-in that supplies the shift source value
`timescale 1ns/1ps
`default_nettype none
module osu_regfile_model (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  output var logic [31:0] rd_data
);
  // Only the bench writes it; the operand path has no way back in
  initial rd_data = 32'h0000_0000;
  always @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      rd_data <= wr_data;
    end
  end
endmodule
`default_nettype wire

// [tb/osu_operand_shifter_properties.sv]
// Checker for the second operand shifter ports
`timescale 1ns/1ps
`default_nettype none
`include "osu_consts.vh"
module osu_operand_shifter_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic use_immediate,
  input wire logic [`OSU_IMM_CODE_W-1:0] imm_code,
  input wire logic [`OSU_DATA_W-1:0] shift_source_register,
  input wire logic [`OSU_KIND_W-1:0] shift_kind,
  input wire logic shift_by_register,
  input wire logic [`OSU_IMM_FIELD_W-1:0] shift_imm_field,
  input wire logic [`OSU_AMT_W-1:0] shift_reg_amount,
  input wire logic sets_flags,
  input wire logic op_execute,
  input wire logic carry_load,
  input wire logic carry_load_value,
  input wire logic [`OSU_DATA_W-1:0] flexible_second_operand,
  input wire logic shifter_carry_out,
  input wire logic carry_update,
  input wire logic carry_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  wire logic by_fld = !use_immediate && !shift_by_register;
  wire logic by_reg = !use_immediate && shift_by_register;
  wire logic [31:0] src = shift_source_register;
  wire logic [7:0] amt = shift_reg_amount;
  // ==========================================================
  // Operand and carry relations
  a_lsl_field: assert property (
    by_fld && shift_kind == `OSU_KIND_LSL && shift_imm_field != 5'h00
    && sets_flags |-> flexible_second_operand == (src << shift_imm_field)
    && carry_update && shifter_carry_out == src[32 - shift_imm_field])
    else $error("left shift result or carry wrong");
  a_zero_pass: assert property (
    by_fld && shift_kind == `OSU_KIND_LSL && shift_imm_field == 5'h00
    |-> flexible_second_operand == src && !carry_update)
    else $error("zero shift not a pass-through");
  a_lsr_carry: assert property (
    by_reg && shift_kind == `OSU_KIND_LSR && amt != 8'h00 && amt < 8'h20
    && sets_flags |-> carry_update && shifter_carry_out == src[amt - 8'h01])
    else $error("right shift carry not last bit out");
  a_asr_wide: assert property (
    by_reg && shift_kind == `OSU_KIND_ASR && amt >= 8'h20 && sets_flags
    |-> flexible_second_operand == {32{src[31]}}
    && shifter_carry_out == src[31])
    else $error("wide arithmetic shift not sign filled");
  a_ror_full: assert property (
    by_reg && shift_kind == `OSU_KIND_ROR && amt == 8'h20 && sets_flags
    |-> flexible_second_operand == src && shifter_carry_out == src[31])
    else $error("rotate by full width wrong");
  a_rrx_shape: assert property (
    !use_immediate && shift_kind == `OSU_KIND_RRX && sets_flags
    |-> flexible_second_operand == {carry_flag, src[31:1]}
    && carry_update && shifter_carry_out == src[0])
    else $error("rotate through carry wrong");
  a_imm_carry: assert property (
    use_immediate && imm_code[11:10] != 2'h0 && sets_flags
    |-> carry_update && shifter_carry_out == flexible_second_operand[31])
    else $error("rotated constant carry not bit 31");
  a_imm_plain: assert property (
    use_immediate && imm_code[11:10] == 2'h0 |-> !carry_update)
    else $error("plain or replicated constant changed carry");
  a_carry_commit: assert property (
    op_execute && carry_update |=> carry_flag == $past(shifter_carry_out))
    else $error("carry flag not committed from shifter");
  c_commit: cover property (op_execute && carry_update);
  c_imm_rot: cover property (use_immediate && carry_update);
  c_rrx: cover property (!use_immediate && shift_kind == `OSU_KIND_RRX);
endmodule
bind osu_operand_shifter osu_operand_shifter_properties u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .use_immediate(use_immediate),
  .imm_code(imm_code), .shift_source_register(shift_source_register),
  .shift_kind(shift_kind), .shift_by_register(shift_by_register),
  .shift_imm_field(shift_imm_field), .shift_reg_amount(shift_reg_amount),
  .sets_flags(sets_flags), .op_execute(op_execute),
  .carry_load(carry_load), .carry_load_value(carry_load_value),
  .flexible_second_operand(flexible_second_operand),
  .shifter_carry_out(shifter_carry_out), .carry_update(carry_update),
  .carry_flag(carry_flag)
);
`default_nettype wire

// [tb/test_osu_operand_shifter.sv]
// Self-checking bench for the second operand shifter
`timescale 1ns/1ps
`default_nettype none
`include "osu_consts.vh"
`define CHK(got, exp) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) \
    begin \
      fails = fails + 1; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_osu_operand_shifter;
  localparam logic [31:0] S = 32'h9000_0005;
  logic ref_clk, reset_n, use_immediate, shift_by_register, sets_flags;
  logic op_execute, carry_load, carry_load_value, wr_en;
  logic [11:0] imm_code;
  logic [2:0] shift_kind;
  logic [4:0] shift_imm_field;
  logic [7:0] shift_reg_amount;
  logic [31:0] wr_data;
  wire logic [31:0] shift_source_register, flexible_second_operand;
  wire logic shifter_carry_out, carry_update, carry_flag;
  int fails, check_count;
  osu_regfile_model u_regs (.ref_clk(ref_clk), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(shift_source_register));
  osu_operand_shifter DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .use_immediate(use_immediate), .imm_code(imm_code),
    .shift_source_register(shift_source_register), .shift_kind(shift_kind),
    .shift_by_register(shift_by_register), .shift_imm_field(shift_imm_field),
    .shift_reg_amount(shift_reg_amount), .sets_flags(sets_flags),
    .op_execute(op_execute), .carry_load(carry_load),
    .carry_load_value(carry_load_value),
    .flexible_second_operand(flexible_second_operand),
    .shifter_carry_out(shifter_carry_out), .carry_update(carry_update),
    .carry_flag(carry_flag));
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // Drivers
  task op(input [2:0] k, input br, input [4:0] f, input [7:0] a,
    input fl, input ex);
    @(posedge ref_clk);
    use_immediate <= 1'b0;
    shift_kind <= k;
    shift_by_register <= br;
    shift_imm_field <= f;
    shift_reg_amount <= a;
    sets_flags <= fl;
    op_execute <= ex;
    @(negedge ref_clk);
  endtask
  task imm(input [11:0] c);
    @(posedge ref_clk);
    use_immediate <= 1'b1;
    imm_code <= c;
    sets_flags <= 1'b1;
    @(negedge ref_clk);
  endtask
  // Sampled in the same cycle as the inputs: the path has no latency
  task exp_out(input [31:0] v, input [1:0] uc);
    `CHK(flexible_second_operand, v)
    `CHK({carry_update, shifter_carry_out}, uc)
  endtask
  task end_sim;
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task t_consts;
    imm(12'h0ab); exp_out(32'h0000_00ab, 2'b00);
    imm(12'h1ab); exp_out(32'h00ab_00ab, 2'b00);
    imm(12'h2ab); exp_out(32'hab00_ab00, 2'b00);
    imm(12'h3ab); exp_out(32'habab_abab, 2'b00);
    imm(12'h42b); exp_out(32'hab00_0000, 2'b11);
    imm(12'hfab); exp_out(32'h0000_0156, 2'b10);
  endtask
  task t_left;
    op(`OSU_KIND_LSL, 0, 5'd1, 8'd0, 1, 0); exp_out(S << 1, 2'b11);
    op(`OSU_KIND_LSL, 0, 5'd31, 8'd0, 1, 0); exp_out(S << 31, 2'b10);
    op(`OSU_KIND_LSL, 0, 5'd0, 8'd0, 1, 0); exp_out(S, 2'b00);
    op(`OSU_KIND_LSL, 1, 5'd0, 8'd32, 1, 0); exp_out(32'h0, 2'b11);
    op(`OSU_KIND_LSL, 1, 5'd0, 8'd33, 1, 0); exp_out(32'h0, 2'b10);
    op(`OSU_KIND_LSL, 1, 5'd0, 8'd0, 1, 0); exp_out(S, 2'b00);
    op(3'h5, 1, 5'd0, 8'd4, 1, 0); exp_out(S, 2'b00);
  endtask
  task t_right;
    op(`OSU_KIND_LSR, 1, 5'd0, 8'd3, 1, 0); exp_out(S >> 3, 2'b11);
    op(`OSU_KIND_LSR, 1, 5'd0, 8'd12, 1, 0); exp_out(S >> 12, 2'b10);
    op(`OSU_KIND_LSR, 0, 5'd0, 8'd0, 1, 0); exp_out(32'h0, 2'b11);
    op(`OSU_KIND_LSR, 1, 5'd0, 8'd33, 1, 0); exp_out(32'h0, 2'b10);
    op(`OSU_KIND_LSR, 0, 5'd3, 8'd0, 0, 0); exp_out(S >> 3, 2'b00);
    op(`OSU_KIND_ASR, 1, 5'd0, 8'd3, 1, 0); exp_out(32'hf200_0000, 2'b11);
    op(`OSU_KIND_ASR, 0, 5'd0, 8'd0, 1, 0); exp_out(32'hffff_ffff, 2'b11);
    op(`OSU_KIND_ASR, 1, 5'd0, 8'd40, 1, 0); exp_out(32'hffff_ffff, 2'b11);
  endtask
  task t_rotate;
    op(`OSU_KIND_ROR, 1, 5'd0, 8'd3, 1, 0); exp_out(32'hb200_0000, 2'b11);
    op(`OSU_KIND_ROR, 1, 5'd0, 8'd32, 1, 0); exp_out(S, 2'b11);
    op(`OSU_KIND_ROR, 1, 5'd0, 8'd35, 1, 0); exp_out(32'hb200_0000, 2'b11);
    op(`OSU_KIND_ROR, 0, 5'd31, 8'd0, 1, 0); exp_out(32'h2000_000b, 2'b10);
  endtask
  // Commits carry, so it runs last and leaves the flag cleared again
  task t_through_carry;
    op(`OSU_KIND_RRX, 0, 5'd0, 8'd0, 1, 1); exp_out(32'h4800_0002, 2'b11);
    op(`OSU_KIND_ROR, 0, 5'd0, 8'd0, 1, 0); exp_out(32'hc800_0002, 2'b11);
    `CHK(carry_flag, 1'b1)
    `CHK(shift_source_register, S)
    @(posedge ref_clk);
    carry_load <= 1'b1;
    carry_load_value <= 1'b0;
    @(posedge ref_clk);
    carry_load <= 1'b0;
    @(negedge ref_clk);
    `CHK(carry_flag, 1'b0)
  endtask
  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    {use_immediate, shift_by_register, sets_flags, op_execute} = 4'h0;
    {carry_load, carry_load_value, wr_en} = 3'h0;
    imm_code = 12'h000;
    shift_kind = 3'h0;
    shift_imm_field = 5'h00;
    shift_reg_amount = 8'h00;
    wr_data = 32'h0000_0000;
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr_en <= 1'b1;
    wr_data <= S;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(carry_flag, 1'b0)
    t_consts;
    t_left;
    t_right;
    t_rotate;
    t_through_carry;
    end_sim;
  end
endmodule
`default_nettype wire
